/* File: rtl/mem_prot_pkg.sv */
// Package: memory map, lock encodings and timing for the memory protection block
// Summary of operation
// RULE1: Flash write op takes effect only when fetched from the boot section.
// RULE2: CPU is stalled while a CPU-started flash operation is in progress.
// RULE3: Boot-section writes may reach any flash address, limited only by locks.
// RULE4: Lock bit writes can only make protection stricter; relaxing is ignored.
// RULE5: Only chip erase clears lock bits, and only after flash is erased; here reset also loads LOCK_RESET, leaving them unprogrammed.
// RULE6: Fuse and lock bits read one when unprogrammed, zero when programmed.
// RULE7: Fuses are written only from the external port; software reads only.
// RULE8: Factory signature row is read-only for everyone.
// RULE9: Chip erase leaves the user signature row; a dedicated erase clears it.
// RULE10: User signature row is one flash page, readable and writable by both; here both can write it, but no read path exists.
// RULE11: Each flash location holds a 16-bit word; instructions use one or two.
// RULE12: Application table equals boot section in size and has its own lock.
// RULE13: Application and boot sections have separate lock bits.
// RULE14: SRAM is decoded from data address 0x2000.
// RULE15: EEPROM is mapped at 0x1000 with byte and page access.
// RULE16: Direct I/O instructions reach I/O 0x00 to 0x3f only.
// RULE17: Single-bit instructions act only on I/O 0x00 to 0x1f.
// RULE18: The four lowest I/O addresses are bit-accessible storage registers.
// RULE19: Load and store move data between 32 working registers and any I/O; here only the four lowest I/O addresses hold data.
// RULE20: Some calibration values load from the signature row during reset; here cal_value loads on the first clock after reset release.
// RULE21: I/O access takes one cycle; SRAM write one, SRAM read two.
// RULE22: EEPROM page load one cycle, read three, burst read every second cycle.
// RULE23: Flash access forbidden by section locks is blocked; contents unchanged.
package mem_prot_pkg;
    localparam int          FLASH_AW       = 8;
    localparam int          PAGE_AW        = 3;
    localparam logic [7:0]  BOOT_START     = 8'he0;
    localparam logic [7:0]  TABLE_START    = 8'hc0;
    localparam logic [15:0] IO_DIRECT_MAX  = 16'h003f;
    localparam logic [15:0] IO_BIT_MAX     = 16'h001f;
    localparam logic [15:0] IO_END         = 16'h0fff;
    localparam logic [15:0] EEPROM_BASE    = 16'h1000;
    localparam logic [15:0] SRAM_BASE      = 16'h2000;
    localparam int          GPIO_REGS      = 4;
    localparam int          WORK_REGS      = 32;
    localparam int          IO_CYCLES      = 1;
    localparam int          SRAM_WR_CYCLES = 1;
    localparam int          SRAM_RD_CYCLES = 2;
    localparam int          EE_LD_CYCLES   = 1;
    localparam int          EE_RD_CYCLES   = 3;
    localparam int          EE_BURST_GAP   = 2;
    localparam real         FLASH_OP_NS    = 200.0;
    localparam real         CLK_NS         = 25.0;
    localparam int          FLASH_OP_CYC   = int'(FLASH_OP_NS / CLK_NS);
    localparam int          ERASE_LOCK_CYC = 1;
    // Lock field: bit1 = write allowed, bit0 = read allowed (1 = unprogrammed)
    localparam logic [1:0]  LOCK_RESET     = 2'h3;
    localparam logic [7:0]  FUSE_RESET     = 8'hff;
    localparam logic [7:0]  CAL_RESET      = 8'h80;

    typedef enum logic [1:0] {REGION_IO, REGION_EEPROM, REGION_SRAM, REGION_NONE} region_t;
    typedef enum logic [1:0] {SEC_APP, SEC_TABLE, SEC_BOOT} section_t;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_PAGE_WRITE, CMD_CHIP_ERASE, CMD_USIG_WRITE,
        CMD_USIG_ERASE, CMD_LOCK_WRITE, CMD_FUSE_WRITE
    } nvm_cmd_t;

    function automatic section_t section_of(input logic [FLASH_AW-1:0] a);
        if (a >= BOOT_START)
            return SEC_BOOT;
        else if (a >= TABLE_START)
            return SEC_TABLE;
        else
            return SEC_APP;
    endfunction

    // Keeps only bits that are programmed (zero) in either value
    function automatic logic [1:0] stricter(input logic [1:0] cur, input logic [1:0] req);
        return cur & req;
    endfunction
endpackage

/* File: rtl/nvm_req_if.sv */
// Interface: request path between memory map and flash controller
`timescale 1ns/1ps
interface nvm_req_if;
    import mem_prot_pkg::*;
    logic                  valid;
    logic                  from_ext;
    logic                  ready;
    nvm_cmd_t              cmd;
    logic [7:0]            addr;
    logic [15:0]           wdata;
    logic [15:0]           rdata;
    logic                  busy;
    modport src (output valid, from_ext, cmd, addr, wdata, input ready, rdata, busy);
    modport dst (input valid, from_ext, cmd, addr, wdata, output ready, rdata, busy);
endinterface

/* File: rtl/data_map.sv */
// Data-space decoder with I/O, EEPROM and SRAM timing
`timescale 1ns/1ps
module data_map
    import mem_prot_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic        direct_io,
    input  wire logic        bit_op,
    input  wire logic        burst,
    input  wire logic [15:0] addr,
    output region_t          region,
    output logic             allowed,
    output logic             done
);
    logic [1:0] wait_cnt;
    logic       busy;
    logic [1:0] need;

    always_comb begin
        if (addr >= SRAM_BASE) // RULE14
            region = REGION_SRAM;
        else if (addr >= EEPROM_BASE) // RULE15
            region = REGION_EEPROM;
        else if (addr <= IO_END)
            region = REGION_IO;
        else
            region = REGION_NONE;
    end

    // RULE16 RULE17
    assign allowed = !(direct_io && addr > IO_DIRECT_MAX) && !(bit_op && addr > IO_BIT_MAX);

    always_comb begin
        case (region)
            REGION_SRAM: need = we ? 2'(SRAM_WR_CYCLES) : 2'(SRAM_RD_CYCLES); // RULE21
            REGION_EEPROM: need = we ? 2'(EE_LD_CYCLES) // RULE22
                                : (burst ? 2'(EE_BURST_GAP) : 2'(EE_RD_CYCLES));
            default: need = 2'(IO_CYCLES);
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 2'h0;
            busy     <= 1'b0;
        end else if (!busy && req && allowed && need > 2'h1) begin
            wait_cnt <= need - 2'h2;
            busy     <= 1'b1;
        end else if (busy && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else begin
            busy <= 1'b0;
        end
    end

    assign done = busy ? (wait_cnt == 2'h0) : (req && (need <= 2'h1 || !allowed));

    chk_sram_read_two: assert property (@(posedge clk) disable iff (rst) // RULE21
        (!busy && req && allowed && region == REGION_SRAM && !we) |-> !done ##1 done)
        else $error("SRAM read not two cycles");
    chk_ee_read_three: assert property (@(posedge clk) disable iff (rst) // RULE22
        (!busy && req && allowed && region == REGION_EEPROM && !we && !burst)
        |-> !done ##1 !done ##1 done)
        else $error("EEPROM read not three cycles");
endmodule

/* File: rtl/flash_ctrl.sv */
// Flash array with section locks, signature rows, fuses and erase sequencing
`timescale 1ns/1ps
module flash_ctrl
    import mem_prot_pkg::*;
#(
    parameter int OP_CYCLES = FLASH_OP_CYC
)(
    input  wire logic       clk,
    input  wire logic       rst,
    nvm_req_if.dst          bus,
    input  wire logic [1:0] lock_req_app,
    input  wire logic [1:0] lock_req_table,
    input  wire logic [1:0] lock_req_boot,
    input  wire logic [7:0] fuse_wdata,
    output logic [1:0]      lock_app,
    output logic [1:0]      lock_table,
    output logic [1:0]      lock_boot,
    output logic [7:0]      fuse,
    output logic [7:0]      cal_value
);
    if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : bad_op_cycles
        $error("OP_CYCLES must lie between 1 and 65535");
    end

    logic [15:0] flash_mem [2**FLASH_AW]; // RULE11
    logic [15:0] usig_mem  [2**PAGE_AW]; // RULE10
    logic [15:0] psig_mem  [2**PAGE_AW];
    logic [15:0] cnt;
    logic        running;
    logic        erase_lock_stage;
    nvm_cmd_t    cur_cmd;
    logic [7:0]  cur_addr;
    logic [15:0] cur_data;
    logic        cur_ext;
    logic [1:0]  sec_lock;

    always_comb begin
        case (section_of(bus.addr))
            SEC_BOOT: sec_lock = lock_boot; // RULE13
            SEC_TABLE: sec_lock = lock_table; // RULE12
            default: sec_lock = lock_app;
        endcase
    end

    assign bus.busy  = running;
    assign bus.ready = !running;

    // Factory row is constant; no port writes it
    always_comb begin
        for (int i = 0; i < 2**PAGE_AW; i++)
            psig_mem[i] = {8'h00, CAL_RESET}; // RULE8
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running          <= 1'b0;
            erase_lock_stage <= 1'b0;
            cnt              <= 16'h0;
            cur_cmd          <= CMD_NONE;
            cur_addr         <= 8'h00;
            cur_data         <= 16'h0;
            cur_ext          <= 1'b0;
        end else if (!running && bus.valid && bus.cmd != CMD_NONE) begin
            running  <= 1'b1;
            cnt      <= 16'(OP_CYCLES);
            cur_cmd  <= bus.cmd;
            cur_addr <= bus.addr;
            cur_data <= bus.wdata;
            cur_ext  <= bus.from_ext;
        end else if (running && cnt > 16'h1) begin
            cnt <= cnt - 16'h1;
        end else if (running && cur_cmd == CMD_CHIP_ERASE && !erase_lock_stage) begin
            erase_lock_stage <= 1'b1; // RULE5
            cnt              <= 16'(ERASE_LOCK_CYC);
        end else begin
            running          <= 1'b0;
            erase_lock_stage <= 1'b0;
        end
    end

    logic finish;
    assign finish = running && cnt <= 16'h1 && !(cur_cmd == CMD_CHIP_ERASE && !erase_lock_stage);

    always_ff @(posedge clk) begin
        if (running && cnt == 16'h1 && cur_cmd == CMD_CHIP_ERASE && !erase_lock_stage) begin
            for (int i = 0; i < 2**FLASH_AW; i++)
                flash_mem[i] <= 16'hffff; // RULE9
        end else if (finish && cur_cmd == CMD_PAGE_WRITE) begin
            flash_mem[cur_addr] <= cur_data; // RULE3
        end
        if (finish && cur_cmd == CMD_USIG_WRITE)
            usig_mem[cur_addr[PAGE_AW-1:0]] <= cur_data; // RULE10
        else if (finish && cur_cmd == CMD_USIG_ERASE)
            for (int i = 0; i < 2**PAGE_AW; i++)
                usig_mem[i] <= 16'hffff; // RULE9
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_app   <= LOCK_RESET;
            lock_table <= LOCK_RESET;
            lock_boot  <= LOCK_RESET;
        end else if (finish && cur_cmd == CMD_CHIP_ERASE) begin
            lock_app   <= LOCK_RESET; // RULE5
            lock_table <= LOCK_RESET;
            lock_boot  <= LOCK_RESET;
        end else if (!running && bus.valid && bus.cmd == CMD_LOCK_WRITE) begin
            lock_app   <= stricter(lock_app, lock_req_app); // RULE4
            lock_table <= stricter(lock_table, lock_req_table);
            lock_boot  <= stricter(lock_boot, lock_req_boot);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            fuse <= FUSE_RESET; // RULE6
        else if (!running && bus.valid && bus.cmd == CMD_FUSE_WRITE && bus.from_ext)
            fuse <= fuse_wdata; // RULE7
    end

    // Calibration reload right after reset release
    logic cal_loaded;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_loaded <= 1'b0;
            cal_value  <= 8'h00;
        end else if (!cal_loaded) begin
            cal_loaded <= 1'b1;
            cal_value  <= psig_mem[0][7:0]; // RULE20
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            bus.rdata <= 16'h0;
        else if (bus.valid && bus.cmd == CMD_NONE)
            bus.rdata <= sec_lock[0] ? flash_mem[bus.addr] : 16'h0; // RULE23
    end

    chk_lock_no_relax: assert property (@(posedge clk) disable iff (rst) // RULE4
        !(running && cur_cmd == CMD_CHIP_ERASE) |=> (lock_boot & ~$past(lock_boot)) == 2'h0)
        else $error("Boot lock relaxed outside chip erase");
    chk_fuse_ext_only: assert property (@(posedge clk) disable iff (rst) // RULE7
        (bus.valid && !bus.from_ext) |=> $stable(fuse))
        else $error("Fuse changed without external port");
endmodule

/* File: rtl/mem_protect.sv */
// Top: memory map and flash protection for the CPU and the external port
`timescale 1ns/1ps
module mem_protect
    import mem_prot_pkg::*;
#(
    parameter int OP_CYCLES = FLASH_OP_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cpu_req,
    input  wire logic        cpu_we,
    input  wire logic        cpu_direct_io,
    input  wire logic        cpu_bit_op,
    input  wire logic        cpu_burst,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic [2:0]  cpu_bit_sel,
    input  wire logic [7:0]  cpu_pc,
    input  wire logic        program_memory_write_op,
    input  wire nvm_cmd_t    cpu_nvm_cmd,
    input  wire logic [7:0]  nvm_addr,
    input  wire logic [15:0] nvm_wdata,
    input  wire logic        ext_req,
    input  wire nvm_cmd_t    ext_nvm_cmd,
    input  wire logic [7:0]  ext_addr,
    input  wire logic [15:0] ext_wdata,
    input  wire logic [5:0]  lock_req,
    input  wire logic [7:0]  fuse_wdata,
    output logic             cpu_stall,
    output logic             cpu_done,
    output logic             cpu_fault,
    output region_t          cpu_region,
    output logic [7:0]       gpio_rdata,
    output logic             gpio_bit,
    output logic [15:0]      nvm_rdata,
    output logic [5:0]       lock_state,
    output logic [7:0]       fuse,
    output logic [7:0]       cal_value
);
    nvm_req_if nvm ();
    logic       allowed;
    logic       io_gp_hit;
    logic [7:0] gp_reg [GPIO_REGS]; // RULE18
    logic       write_ok;
    logic       lock_ok;
    logic [1:0] lock_app;
    logic [1:0] lock_table;
    logic [1:0] lock_boot;
    logic [1:0] tgt_lock;

    data_map data_map_inst (
        .clk       (clk),
        .rst       (rst),
        .req       (cpu_req),
        .we        (cpu_we),
        .direct_io (cpu_direct_io),
        .bit_op    (cpu_bit_op),
        .burst     (cpu_burst),
        .addr      (cpu_addr),
        .region    (cpu_region),
        .allowed   (allowed),
        .done      (cpu_done)
    );

    assign cpu_fault = cpu_req && !allowed;
    assign io_gp_hit = cpu_req && allowed && cpu_addr < 16'(GPIO_REGS);

    // Storage read/written by load/store and single-bit ops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < GPIO_REGS; i++)
                gp_reg[i] <= 8'h00;
        end else if (io_gp_hit && cpu_we && cpu_bit_op) begin
            gp_reg[cpu_addr[1:0]][cpu_bit_sel] <= cpu_wdata[0]; // RULE18
        end else if (io_gp_hit && cpu_we) begin
            gp_reg[cpu_addr[1:0]] <= cpu_wdata; // RULE19
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpio_rdata <= 8'h00;
            gpio_bit   <= 1'b0;
        end else if (io_gp_hit && !cpu_we) begin
            gpio_rdata <= gp_reg[cpu_addr[1:0]];
            gpio_bit   <= gp_reg[cpu_addr[1:0]][cpu_bit_sel]; // RULE17
        end
    end

    always_comb begin
        case (section_of(ext_req ? ext_addr : nvm_addr))
            SEC_BOOT: tgt_lock = lock_boot;
            SEC_TABLE: tgt_lock = lock_table;
            default: tgt_lock = lock_app;
        endcase
    end

    // Page writes need the target write lock open; other commands pass
    assign lock_ok  = (ext_req ? ext_nvm_cmd : cpu_nvm_cmd) != CMD_PAGE_WRITE || tgt_lock[1];
    assign write_ok = program_memory_write_op && section_of(cpu_pc) == SEC_BOOT // RULE1
                      && cpu_nvm_cmd != CMD_FUSE_WRITE;

    assign nvm.valid    = (ext_req || write_ok) && lock_ok; // RULE23
    assign nvm.from_ext = ext_req;
    assign nvm.cmd      = ext_req ? ext_nvm_cmd : cpu_nvm_cmd;
    assign nvm.addr     = ext_req ? ext_addr : nvm_addr;
    assign nvm.wdata    = ext_req ? ext_wdata : nvm_wdata;

    flash_ctrl #(.OP_CYCLES(OP_CYCLES)) flash_ctrl_inst (
        .clk            (clk),
        .rst            (rst),
        .bus            (nvm),
        .lock_req_app   (lock_req[1:0]),
        .lock_req_table (lock_req[3:2]),
        .lock_req_boot  (lock_req[5:4]),
        .fuse_wdata     (fuse_wdata),
        .lock_app       (lock_app),
        .lock_table     (lock_table),
        .lock_boot      (lock_boot),
        .fuse           (fuse),
        .cal_value      (cal_value)
    );

    assign cpu_stall  = nvm.busy || (write_ok && nvm.valid); // RULE2
    assign nvm_rdata  = nvm.rdata;
    assign lock_state = {lock_boot, lock_table, lock_app}; // RULE6

    chk_app_write_dead: assert property (@(posedge clk) disable iff (rst) // RULE1
        (program_memory_write_op && !ext_req && section_of(cpu_pc) != SEC_BOOT
         && !nvm.busy) |=> !nvm.busy)
        else $error("Flash op started from application code");
    chk_stall_busy: assert property (@(posedge clk) disable iff (rst) // RULE2
        (write_ok && nvm.valid && !nvm.busy && nvm.cmd != CMD_NONE)
        |-> cpu_stall ##1 (nvm.busy && cpu_stall))
        else $error("CPU not stalled during flash op");
    chk_gp_write: assert property (@(posedge clk) disable iff (rst) // RULE19
        (io_gp_hit && cpu_we && !cpu_bit_op) |=> gp_reg[$past(cpu_addr[1:0])] == $past(cpu_wdata))
        else $error("General purpose register write lost");
    chk_direct_range: assert property (@(posedge clk) disable iff (rst) // RULE16
        (cpu_req && cpu_direct_io && cpu_addr > IO_DIRECT_MAX) |-> cpu_fault)
        else $error("Direct I/O beyond range accepted");
endmodule

/* File: test/flash_host_model.sv */
// CPU fetch side and external programmer issuing flash commands
`timescale 1ns/1ps
module flash_host_model
    import mem_prot_pkg::*;
#(
    parameter int OP_CYCLES = 4
)(
    input  wire logic   clk,
    input  wire logic   cpu_stall,
    output logic [7:0]  cpu_pc,
    output logic        program_memory_write_op,
    output nvm_cmd_t    cpu_nvm_cmd,
    output logic [7:0]  nvm_addr,
    output logic [15:0] nvm_wdata,
    output logic        ext_req,
    output nvm_cmd_t    ext_nvm_cmd,
    output logic [7:0]  ext_addr,
    output logic [15:0] ext_wdata
);
    initial begin
        cpu_pc = 8'h00;
        program_memory_write_op = 1'b0;
        cpu_nvm_cmd = CMD_NONE;
        nvm_addr = 8'h00;
        nvm_wdata = 16'h0000;
        ext_req = 1'b0;
        ext_nvm_cmd = CMD_NONE;
        ext_addr = 8'h00;
        ext_wdata = 16'h0000;
    end

    task automatic cpu_op(input logic [7:0] pc, input nvm_cmd_t cmd, input logic [7:0] a,
                          input logic [15:0] d, output int n);
        n = 0;
        @(posedge clk);
        #1;
        cpu_pc = pc;
        cpu_nvm_cmd = cmd;
        nvm_addr = a;
        nvm_wdata = d;
        program_memory_write_op = 1'b1;
        @(posedge clk);
        #1;
        program_memory_write_op = 1'b0;
        nvm_addr = ~a;
        nvm_wdata = ~d;
        // Core sits halted while the flash is busy
        while (cpu_stall === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic ext_op(input nvm_cmd_t cmd, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        ext_nvm_cmd = cmd;
        ext_addr = a;
        ext_wdata = d;
        ext_req = 1'b1;
        @(posedge clk);
        #1;
        ext_req = 1'b0;
        ext_addr = ~a;
        ext_wdata = ~d;
        // Port waits out the operation plus the lock clear step
        repeat (OP_CYCLES + 3) @(posedge clk);
        #1;
    endtask
endmodule

/* File: test/mem_protect_tb.sv */
// Self-checking bench for the memory map and flash protection block
`timescale 1ns/1ps
module mem_protect_tb;
    import mem_prot_pkg::*;
    localparam int OPC = 4;
    logic clk = 1'b0, rst = 1'b1, cpu_req = 1'b0, cpu_we = 1'b0, cpu_direct_io = 1'b0;
    logic cpu_bit_op = 1'b0, cpu_burst = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00, fuse_wdata = 8'hff, cpu_pc, nvm_addr, ext_addr, rd_byte;
    logic [2:0]  cpu_bit_sel = 3'h0;
    logic [5:0]  lock_req = 6'h3f, lock_state;
    logic [15:0] nvm_wdata, ext_wdata, nvm_rdata;
    logic        pm_op, ext_req, cpu_stall, cpu_done, cpu_fault, gpio_bit, rd_bit;
    nvm_cmd_t    cpu_nvm_cmd, ext_nvm_cmd;
    region_t     cpu_region;
    logic [7:0]  gpio_rdata, fuse, cal_value;
    int          miscompares = 0, total_checks = 0, n;

    always #12.5 clk = ~clk;

    mem_protect #(.OP_CYCLES(OPC)) mem_protect_inst (
        .clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_direct_io(cpu_direct_io), .cpu_bit_op(cpu_bit_op), .cpu_burst(cpu_burst),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_bit_sel(cpu_bit_sel),
        .cpu_pc(cpu_pc), .program_memory_write_op(pm_op), .cpu_nvm_cmd(cpu_nvm_cmd),
        .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .ext_req(ext_req),
        .ext_nvm_cmd(ext_nvm_cmd), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .lock_req(lock_req), .fuse_wdata(fuse_wdata), .cpu_stall(cpu_stall),
        .cpu_done(cpu_done), .cpu_fault(cpu_fault), .cpu_region(cpu_region),
        .gpio_rdata(gpio_rdata), .gpio_bit(gpio_bit), .nvm_rdata(nvm_rdata),
        .lock_state(lock_state), .fuse(fuse), .cal_value(cal_value));

    flash_host_model #(.OP_CYCLES(OPC)) flash_host_model_inst (
        .clk(clk), .cpu_stall(cpu_stall), .cpu_pc(cpu_pc), .program_memory_write_op(pm_op),
        .cpu_nvm_cmd(cpu_nvm_cmd), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .ext_req(ext_req), .ext_nvm_cmd(ext_nvm_cmd), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata));

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_region(input region_t got, input region_t exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t region got %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One data-space access; latency, fault and region judged here
    task automatic data_acc(input logic [15:0] a, input logic we, input logic dio,
                            input logic bop, input logic bst, input logic [2:0] bs,
                            input logic [7:0] wd, input region_t er, input int lat,
                            input logic ef);
        int k;
        k = 0;
        cpu_addr = a;
        cpu_we = we;
        cpu_direct_io = dio;
        cpu_bit_op = bop;
        cpu_burst = bst;
        cpu_bit_sel = bs;
        cpu_wdata = wd;
        cpu_req = 1'b1;
        #1;
        while (cpu_done !== 1'b1 && k < 6) begin
            @(posedge clk);
            #1;
            k++;
        end
        check_val(16'(k), 16'(lat), "latency");
        check_val({15'h0, cpu_fault}, {15'h0, ef}, "fault");
        check_region(cpu_region, er);
        @(posedge clk);
        #1;
        rd_byte = gpio_rdata;
        rd_bit = gpio_bit;
        cpu_req = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic flash_read(input logic [7:0] a, input logic [15:0] exp);
        flash_host_model_inst.ext_op(CMD_NONE, a, 16'h0000);
        check_val(nvm_rdata, exp, "flash read");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check_val({10'h0, lock_state}, 16'h003f, "lock reset");
        check_val({8'h0, fuse}, 16'h00ff, "fuse reset");
        check_val({8'h0, cal_value}, 16'h0080, "calibration");
        data_acc(16'h0010, 0, 0, 0, 0, 3'h0, 8'h00, REGION_IO, 0, 0);
        data_acc(16'h0fff, 1, 0, 0, 0, 3'h0, 8'h11, REGION_IO, 0, 0);
        data_acc(16'h2000, 1, 0, 0, 0, 3'h0, 8'h22, REGION_SRAM, 0, 0);
        data_acc(16'h2000, 0, 0, 0, 0, 3'h0, 8'h00, REGION_SRAM, 1, 0);
        data_acc(16'h1000, 1, 0, 0, 0, 3'h0, 8'h33, REGION_EEPROM, 0, 0);
        data_acc(16'h1000, 0, 0, 0, 0, 3'h0, 8'h00, REGION_EEPROM, 2, 0);
        data_acc(16'h1001, 0, 0, 0, 1, 3'h0, 8'h00, REGION_EEPROM, 1, 0);
        data_acc(16'h003f, 0, 1, 0, 0, 3'h0, 8'h00, REGION_IO, 0, 0);
        data_acc(16'h0040, 0, 1, 0, 0, 3'h0, 8'h00, REGION_IO, 0, 1);
        data_acc(16'h001f, 0, 0, 1, 0, 3'h0, 8'h00, REGION_IO, 0, 0);
        data_acc(16'h0020, 1, 0, 1, 0, 3'h0, 8'h01, REGION_IO, 0, 1);
        data_acc(16'h0001, 1, 0, 0, 0, 3'h0, 8'h5a, REGION_IO, 0, 0);
        data_acc(16'h0001, 0, 0, 0, 0, 3'h0, 8'h00, REGION_IO, 0, 0);
        check_val({8'h0, rd_byte}, 16'h005a, "io byte");
        data_acc(16'h0002, 1, 0, 1, 0, 3'h3, 8'h01, REGION_IO, 0, 0);
        data_acc(16'h0002, 0, 0, 1, 0, 3'h3, 8'h00, REGION_IO, 0, 0);
        check_val({15'h0, rd_bit}, 16'h0001, "io bit");
        data_acc(16'h0002, 0, 0, 0, 0, 3'h0, 8'h00, REGION_IO, 0, 0);
        check_val({8'h0, rd_byte}, 16'h0008, "io bit byte");
        data_acc(16'h0002, 1, 0, 1, 0, 3'h3, 8'h00, REGION_IO, 0, 0);
        data_acc(16'h0002, 0, 0, 0, 0, 3'h0, 8'h00, REGION_IO, 0, 0);
        check_val({8'h0, rd_byte}, 16'h0000, "io bit clear");
        flash_host_model_inst.ext_op(CMD_PAGE_WRITE, 8'h10, 16'h1234);
        flash_read(8'h10, 16'h1234);
        flash_host_model_inst.ext_op(CMD_PAGE_WRITE, 8'h20, 16'h0000);
        flash_host_model_inst.cpu_op(8'h10, CMD_PAGE_WRITE, 8'h20, 16'hbeef, n);
        check_val(16'(n), 16'h0000, "app fetch stall");
        flash_read(8'h20, 16'h0000);
        flash_host_model_inst.cpu_op(8'he0, CMD_PAGE_WRITE, 8'hf0, 16'ha5c3, n);
        check_val(16'(n), 16'(OPC), "stall length");
        flash_read(8'hf0, 16'ha5c3);
        lock_req = 6'b11_10_01;
        flash_host_model_inst.ext_op(CMD_LOCK_WRITE, 8'h00, 16'h0000);
        check_val({10'h0, lock_state}, 16'h0039, "lock set");
        lock_req = 6'h3f;
        flash_host_model_inst.cpu_op(8'he0, CMD_LOCK_WRITE, 8'h00, 16'h0000, n);
        flash_host_model_inst.ext_op(CMD_LOCK_WRITE, 8'h00, 16'h0000);
        check_val({10'h0, lock_state}, 16'h0039, "lock relax");
        flash_host_model_inst.ext_op(CMD_PAGE_WRITE, 8'h10, 16'h5555);
        flash_read(8'h10, 16'h1234);
        flash_host_model_inst.ext_op(CMD_PAGE_WRITE, 8'hc0, 16'h0f0f);
        flash_read(8'hc0, 16'h0000);
        fuse_wdata = 8'h3c;
        flash_host_model_inst.cpu_op(8'he0, CMD_FUSE_WRITE, 8'h00, 16'h0000, n);
        check_val({8'h0, fuse}, 16'h00ff, "cpu fuse");
        flash_host_model_inst.ext_op(CMD_FUSE_WRITE, 8'h00, 16'h0000);
        check_val({8'h0, fuse}, 16'h003c, "ext fuse");
        flash_host_model_inst.ext_op(CMD_USIG_WRITE, 8'h01, 16'h6a6a);
        flash_host_model_inst.cpu_op(8'he0, CMD_USIG_WRITE, 8'h02, 16'h1111, n);
        check_val(mem_protect_inst.flash_ctrl_inst.usig_mem[2], 16'h1111, "usig cpu");
        flash_host_model_inst.ext_op(CMD_CHIP_ERASE, 8'h00, 16'h0000);
        check_val({10'h0, lock_state}, 16'h003f, "erase locks");
        flash_read(8'h10, 16'hffff);
        check_val(mem_protect_inst.flash_ctrl_inst.usig_mem[1], 16'h6a6a, "usig kept");
        flash_host_model_inst.ext_op(CMD_USIG_ERASE, 8'h00, 16'h0000);
        check_val(mem_protect_inst.flash_ctrl_inst.usig_mem[1], 16'hffff, "usig erase");
        end_sim();
    end

    initial begin
        #(25 * 5000);
        miscompares++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_sim();
    end
endmodule
